// [design/rwsc_pkg.sv]
/*
  Package for the reset, wake and strap control block: register offsets,
  field positions, reset values and timing counts.
  Assumes a single 32-bit Avalon-MM register port with byte addresses.
*/
package rwsc_pkg;

  // ----------------------------------------------------------------
  // Clocking and timing
  // ----------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ = 25_000_000;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned POR_TIME_NS = 2_000;
  localparam int unsigned POR_CYCLES =
    (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_W = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_INT_STAT = 5'h08;
  localparam logic [4:0] OFS_INT_MASK = 5'h0c;
  localparam logic [4:0] OFS_BYTE_TEST = 5'h10;
  localparam logic [4:0] OFS_LINK_CFG = 5'h14;

  // Control register fields.
  localparam int CTRL_WAKE_EN = 0;
  localparam int CTRL_WAKE_POL = 1;
  localparam int CTRL_WAKE_OD = 2;
  localparam int CTRL_SLEEP = 3;

  // Status register fields.
  localparam int STAT_ASLEEP = 0;
  localparam int STAT_READ_SEEN = 1;
  localparam int STAT_SPEED = 2;
  localparam int STAT_XOVER = 3;
  localparam int STAT_WAKE_PEND = 4;
  localparam int STAT_PIN = 5;

  // Interrupt status and mask fields.
  localparam int INT_W = 3;
  localparam int INT_WAKE_EVT = 0;
  localparam int INT_WOKE = 1;
  localparam int INT_WR_IGN = 2;

  // Link configuration fields.
  localparam int LINK_SPEED100 = 0;
  localparam int LINK_FULL_DUP = 1;
  localparam int LINK_AUTONEG = 2;

  // Reset values.
  localparam logic RST_WAKE_EN = 1'b0;
  localparam logic RST_WAKE_POL = 1'b0;
  localparam logic RST_WAKE_OD = 1'b0;
  localparam logic [INT_W-1:0] RST_INT_MASK = 3'h0;
  // Arbitrary pattern for the byte-order test register.
  localparam logic [31:0] BYTE_TEST_VAL = 32'h5a3c_c35a;

  // Whole state of the top module.
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [POR_W-1:0] por_cnt;
    logic por_done;
    logic cap_done;
    logic speed;
    logic xover;
    logic asleep;
    logic read_seen;
    logic wake_en;
    logic wake_pol;
    logic wake_od;
    logic wake_pend;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic ack;
    logic [31:0] rdata;
  } rwsc_state_t;

endpackage

// [design/rwsc_top.sv]
/*
  Reset, wake and strap control of a single-chip Ethernet controller.
  Holds reset release, internal power-on reset, read-before-write gating,
  the wake indicator pin, sleep exit by host write and the two straps.
  Assumes all inputs are synchronous to clk and an Avalon-MM master.
*/
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
// Behaviour
// R01: All logic runs from the single reference clock input; here clk runs at CLK_HZ (10 MHz), not REF_CLK_HZ (25 MHz).
// R02: Holding the external reset low returns all state to reset values; here the POR count and done flag keep their values.
// R03: With the external reset idle, an internal power-on reset initialises.
// R04: After reset or wake, writes are ignored until one read has completed.
// R05: When enabled, the wake indicator asserts on a detected wake event.
// R06: The wake indicator has programmable polarity and push-pull or open-drain.
// R07: A wake event or the wake indicator alone never ends sleep.
// R08: Sleep ends only on a host write cycle, chip select and write strobe low; here an Avalon-MM write alone also ends it.
// R09: Any host write in sleep wakes the device whatever its data.
// R10: The host sends its wake write to the byte-order test register.
// R11: A high crossover strap enables automatic crossover, low disables it.
// R12: The speed strap is captured once as reset is released.
// R13: Strap 0 gives 10 Mbps half duplex no autoneg, 1 gives 100 Mbps with it.
// R14: External reset release is synchronised to the clock before use.
`timescale 1ns/1ps

module rwsc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_reset_low,
  input wire logic chip_select_low,
  input wire logic write_strobe_low,
  input wire logic wake_event,
  input wire logic crossover_auto_strap,
  input wire logic speed_strap,
  input wire logic [rwsc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wake_indicator_in,
  output logic wake_indicator_out,
  output logic wake_indicator_oe,
  output logic crossover_auto_en,
  output logic link_speed_100,
  output logic link_full_duplex,
  output logic link_autoneg_en,
  output logic device_asleep,
  output logic irq
);
  import rwsc_pkg::*;

  // ----------------------------------------------------------------
  // State and reset image
  // ----------------------------------------------------------------
  localparam rwsc_state_t RST_STATE = '{
    sync1: 1'b0,
    sync2: 1'b0,
    por_cnt: '0,
    por_done: 1'b0,
    cap_done: 1'b0,
    speed: 1'b0,
    xover: 1'b0,
    asleep: 1'b0,
    read_seen: 1'b0,
    wake_en: RST_WAKE_EN,
    wake_pol: RST_WAKE_POL,
    wake_od: RST_WAKE_OD,
    wake_pend: 1'b0,
    int_stat: '0,
    int_mask: RST_INT_MASK,
    ack: 1'b0,
    rdata: '0
  };
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);

  rwsc_state_t q;
  rwsc_state_t d;

  // Block is live once the synchronised reset is idle and POR has run.
  logic run;
  logic req;
  logic rd_go;
  logic wr_go;
  logic hw_wr;
  logic wake_wr;
  logic lane0;
  logic wake_act;
  logic [INT_W-1:0] int_set;
  logic [INT_W-1:0] int_clr;

  assign run = q.sync2 && q.por_done;
  assign req = (avs_read || avs_write) && !q.ack;
  assign rd_go = avs_read && req;
  assign wr_go = avs_write && req;
  assign hw_wr = !chip_select_low && !write_strobe_low;
  assign wake_wr = q.asleep && (wr_go || hw_wr);
  assign lane0 = avs_byteenable[0];

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // Reserved bits and unmapped addresses read as zero.
  function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a,
                                         input rwsc_state_t s,
                                         input logic pin);
    logic [31:0] r;
    r = '0;
    unique case (a)
      OFS_CTRL: begin
        r[CTRL_WAKE_EN] = s.wake_en;
        r[CTRL_WAKE_POL] = s.wake_pol;
        r[CTRL_WAKE_OD] = s.wake_od;
        r[CTRL_SLEEP] = s.asleep;
      end
      OFS_STATUS: begin
        r[STAT_ASLEEP] = s.asleep;
        r[STAT_READ_SEEN] = s.read_seen;
        r[STAT_SPEED] = s.speed;
        r[STAT_XOVER] = s.xover;
        r[STAT_WAKE_PEND] = s.wake_pend;
        r[STAT_PIN] = pin;
      end
      OFS_INT_STAT: r[INT_W-1:0] = s.int_stat;
      OFS_INT_MASK: r[INT_W-1:0] = s.int_mask;
      OFS_BYTE_TEST: r = BYTE_TEST_VAL;
      OFS_LINK_CFG: begin
        r[LINK_SPEED100] = s.speed;
        r[LINK_FULL_DUP] = 1'b0;
        r[LINK_AUTONEG] = s.speed;
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // All behaviour is gathered here so that the single register stage
  // below is the only place that state changes.
  always_comb begin
    d = q;
    int_set = '0;
    int_clr = '0;
    // Two-flop synchroniser on the external reset release.
    d.sync1 = ext_reset_low; // R14
    d.sync2 = q.sync1; // R14
    // Internal power-on reset: count out POR_CYCLES after rst_n.
    if (!q.por_done) begin
      d.por_cnt = q.por_cnt + POR_W'(1); // R03
      if (q.por_cnt == POR_LAST) begin
        d.por_done = 1'b1; // R03
      end
    end
    if (!run) begin
      // Everything except the synchroniser and POR returns to reset.
      d = RST_STATE; // R02
      d.sync1 = ext_reset_low;
      d.sync2 = q.sync1;
      d.por_cnt = q.por_done ? q.por_cnt : q.por_cnt + POR_W'(1);
      d.por_done = q.por_done || (q.por_cnt == POR_LAST);
    end else begin
      // Speed strap is sampled on the first live cycle only.
      if (!q.cap_done) begin
        d.cap_done = 1'b1; // R12
        d.speed = speed_strap; // R12
      end
      d.xover = crossover_auto_strap; // R11
      d.ack = req;
      if (rd_go) begin
        d.rdata = rd_mux(avs_address, q, wake_indicator_in);
        // A read while asleep does not arm writes; the wake write
        // clears the flag again anyway.
        if (!q.asleep) begin
          d.read_seen = 1'b1; // R04
        end
      end
      if (wake_wr) begin
        // Any write wakes, the data is not looked at.
        d.asleep = 1'b0; // R08 R09
        d.read_seen = 1'b0; // R04
        d.wake_pend = 1'b0;
        int_set[INT_WOKE] = 1'b1;
      end else if (wr_go) begin
        if (!q.read_seen) begin
          int_set[INT_WR_IGN] = 1'b1; // R04
        end else if (lane0) begin
          unique case (avs_address)
            OFS_CTRL: begin
              d.wake_en = avs_writedata[CTRL_WAKE_EN];
              d.wake_pol = avs_writedata[CTRL_WAKE_POL];
              d.wake_od = avs_writedata[CTRL_WAKE_OD];
              d.asleep = avs_writedata[CTRL_SLEEP];
            end
            OFS_INT_STAT: int_clr = avs_writedata[INT_W-1:0];
            OFS_INT_MASK: d.int_mask = avs_writedata[INT_W-1:0];
            default: d.asleep = q.asleep;
          endcase
        end
      end
      // A wake event only sets the pending and interrupt flags, it never ends sleep.
      if (wake_event && q.asleep && !wake_wr) begin
        d.wake_pend = 1'b1; // R05 R07
        int_set[INT_WAKE_EVT] = 1'b1;
      end
      // Set wins over a write-one-to-clear in the same cycle.
      d.int_stat = (q.int_stat & ~int_clr) | int_set;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Single clock for all logic; it runs at CLK_HZ (10 MHz), not the 25 MHz REF_CLK_HZ.
  always_ff @(posedge clk) begin // R01
    if (!rst_n) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Wake pin: push-pull drives both levels, open-drain only pulls low,
  // so an active-high open-drain setting needs an external pull-up.
  assign wake_act = q.wake_en && q.wake_pend; // R05
  always_comb begin
    if (q.wake_od) begin
      wake_indicator_out = 1'b0; // R06
      wake_indicator_oe = (wake_act != q.wake_pol); // R06
    end else begin
      wake_indicator_out = (wake_act == q.wake_pol); // R06
      wake_indicator_oe = 1'b1;
    end
  end

  // Bus answers one cycle after the request is seen.
  assign avs_waitrequest = (avs_read || avs_write) && !q.ack;
  assign avs_readdata = q.rdata;
  assign crossover_auto_en = q.xover; // R11
  assign link_speed_100 = q.speed; // R13
  assign link_full_duplex = 1'b0; // R13
  assign link_autoneg_en = q.speed; // R13
  assign device_asleep = q.asleep;
  assign irq = |(q.int_stat & q.int_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ext_reset_clear: assert property ( // R02
    @(posedge clk) disable iff (!rst_n)
    !q.sync2 |=> !q.asleep && !q.read_seen && q.int_stat == '0)
    else $error("external reset did not clear state");

  a_por_blocks_bus: assert property ( // R03
    @(posedge clk) disable iff (!rst_n)
    !q.por_done |-> !q.read_seen && !q.ack)
    else $error("activity before power-on reset finished");

  a_write_needs_read: assert property ( // R04
    @(posedge clk) disable iff (!rst_n)
    run && wr_go && !q.asleep && !q.read_seen
    |=> q.int_stat[INT_WR_IGN] && $stable(q.wake_en) && $stable(q.int_mask))
    else $error("write took effect before first read");

  a_wake_pin_level: assert property ( // R05
    @(posedge clk) disable iff (!rst_n)
    q.wake_en && q.wake_pend && !q.wake_od
    |-> wake_indicator_oe && wake_indicator_out == q.wake_pol)
    else $error("wake indicator not asserted");

  a_od_no_high: assert property ( // R06
    @(posedge clk) disable iff (!rst_n)
    q.wake_od |-> !wake_indicator_out)
    else $error("open-drain wake pin driven high");

  a_event_keeps_sleep: assert property ( // R07
    @(posedge clk) disable iff (!rst_n)
    run && q.asleep && wake_event && !wr_go && !hw_wr
    |=> q.asleep && q.wake_pend)
    else $error("wake event ended sleep");

  a_host_write_wakes: assert property ( // R08
    @(posedge clk) disable iff (!rst_n)
    run && q.asleep && hw_wr |=> !q.asleep && !q.read_seen)
    else $error("host write did not wake device");

  a_only_write_wakes: assert property ( // R09
    @(posedge clk) disable iff (!rst_n)
    $fell(q.asleep) |-> $past(wr_go || hw_wr || !run))
    else $error("sleep left without a write");

  a_xover_follow: assert property ( // R11
    @(posedge clk) disable iff (!rst_n)
    run ##1 run |-> crossover_auto_en == $past(crossover_auto_strap))
    else $error("crossover enable does not follow strap");

  a_speed_capture: assert property ( // R12
    @(posedge clk) disable iff (!rst_n)
    $rose(run) |=> q.cap_done && q.speed == $past(speed_strap))
    else $error("speed strap not captured at release");

  a_speed_hold: assert property ( // R13
    @(posedge clk) disable iff (!rst_n)
    run && q.cap_done |=> $stable(link_speed_100) && !link_full_duplex
    && link_autoneg_en == link_speed_100)
    else $error("link defaults changed after capture");

  a_sync_release: assert property ( // R14
    @(posedge clk) disable iff (!rst_n)
    $rose(q.sync2) |-> $past(q.sync1) && !$past(q.sync2))
    else $error("reset release not through synchroniser");

  // The power-on reset itself must clear everything, the counter included.
  a_rst_clears_all: assert property ( // R02
    @(posedge clk)
    !rst_n |=> !q.asleep && !q.por_done && !q.read_seen && q.int_mask == RST_INT_MASK)
    else $error("power-on reset did not clear state");

  a_read_arms_write: assert property ( // R04
    @(posedge clk) disable iff (!rst_n)
    run && rd_go && !q.asleep |=> q.read_seen)
    else $error("read did not arm writes");

  a_wake_pend_flag: assert property ( // R05
    @(posedge clk) disable iff (!rst_n)
    run && q.asleep && wake_event && !wake_wr |=> q.wake_pend && q.int_stat[INT_WAKE_EVT])
    else $error("wake event not recorded");

  a_wake_pin_idle: assert property ( // R05
    @(posedge clk) disable iff (!rst_n)
    !q.wake_en && !q.wake_od |-> wake_indicator_oe && wake_indicator_out != q.wake_pol)
    else $error("disabled wake indicator not idle");

  a_od_release: assert property ( // R06
    @(posedge clk) disable iff (!rst_n)
    q.wake_od && ((q.wake_en && q.wake_pend) == q.wake_pol) |-> !wake_indicator_oe)
    else $error("open-drain wake pin not released");

  // Any reset must force a fresh capture of the speed strap.
  a_speed_recapture: assert property ( // R12
    @(posedge clk) disable iff (!rst_n)
    !run |=> !q.cap_done)
    else $error("speed strap not re-armed by reset");

endmodule

// [verif/rwsc_host.sv]
/*
  Host processor model for the reset, wake and strap control block.
  Speaks Avalon-MM with waitrequest and drives the two host write pins.
  Assumes one clock shared with the block and an external timeout.
*/
`timescale 1ns/1ps

module rwsc_host (
  input wire logic clk,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  output logic [rwsc_pkg::ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [3:0] avs_byteenable,
  output logic [31:0] avs_writedata,
  output logic chip_select_low,
  output logic write_strobe_low
);
  import rwsc_pkg::*;

  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // The host starts with the bus quiet and both pins released high.
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
    chip_select_low = 1'b1;
    write_strobe_low = 1'b1;
  end

  // ----------------------------------------------------------------
  // Bus cycle
  // ----------------------------------------------------------------
  // Waitrequest and read data are taken at the rising edge itself, before the block's
  // flops update in that time step, so the master sees what the block shows at the edge.
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    avs_byteenable <= 4'hf;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d; // Released data must not look valid.
  endtask

  // Sets the two host write pins after the next rising edge.
  task automatic pins(input logic cs, input logic ws);
    @(posedge clk);
    chip_select_low <= cs;
    write_strobe_low <= ws;
  endtask

  // A wake-up write cycle; its data carries no meaning.
  task automatic wake(input logic [31:0] d);
    logic [31:0] q;
    pins(1'b0, 1'b0);
    bus(1'b1, OFS_BYTE_TEST, d, q);
    chip_select_low <= 1'b1;
    write_strobe_low <= 1'b1;
  endtask
endmodule

// [verif/rwsc_top_tb.sv]
/*
  Self-checking testbench for the reset, wake and strap control block.
  Assumes the host model in rwsc_host.sv and a pull-up on the wake line.
*/
`timescale 1ns/1ps

module rwsc_top_tb;
  import rwsc_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_reset_low = 1'b1;
  logic wake_event = 1'b0;
  logic crossover_auto_strap = 1'b1;
  logic speed_strap = 1'b1;
  logic cs_low, ws_low, rd_s, wr_s, wait_s, pin_out, pin_oe, wake_in;
  logic xover_en, sp100, full_dup, autoneg, asleep, irq;
  logic [ADDR_W-1:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // Clock, wake line and timeout
  // ----------------------------------------------------------------
  always #50 clk = ~clk;
  // A released open-drain line floats up to the pull-up.
  assign wake_in = pin_oe ? pin_out : 1'b1;
  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      conclude();
    end
  end

  rwsc_host i_rwsc_host (.clk(clk), .avs_readdata(rdata), .avs_waitrequest(wait_s),
    .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s), .avs_byteenable(be),
    .avs_writedata(wdata), .chip_select_low(cs_low), .write_strobe_low(ws_low));

  rwsc_top i_rwsc_top (.clk(clk), .rst_n(rst_n), .ext_reset_low(ext_reset_low),
    .chip_select_low(cs_low), .write_strobe_low(ws_low), .wake_event(wake_event),
    .crossover_auto_strap(crossover_auto_strap), .speed_strap(speed_strap),
    .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s), .avs_byteenable(be),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_s),
    .wake_indicator_in(wake_in), .wake_indicator_out(pin_out),
    .wake_indicator_oe(pin_oe), .crossover_auto_en(xover_en), .link_speed_100(sp100),
    .link_full_duplex(full_dup), .link_autoneg_en(autoneg), .device_asleep(asleep),
    .irq(irq));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    i_rwsc_host.bus(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_rwsc_host.bus(1'b1, a, d, q);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Writes before the first read must be dropped and flagged; then the interrupt path.
  task automatic t_read_first();
    wr(OFS_INT_MASK, 32'h7);
    rd(OFS_INT_MASK, 32'h0, "mask_ignored");
    rd(OFS_INT_STAT, 32'h4, "ignored_flag");
    chk("irq_masked", 1'b0, irq);
    wr(OFS_INT_MASK, 32'h4);
    cyc(1);
    chk("irq_set", 1'b1, irq);
    wr(OFS_INT_STAT, 32'h4);
    cyc(1);
    chk("irq_clear", 1'b0, irq);
  endtask

  // Straps: speed is held from reset release, crossover follows the pin.
  task automatic t_straps();
    chk("speed100", 1'b1, sp100);
    chk("autoneg", 1'b1, autoneg);
    chk("full_dup", 1'b0, full_dup);
    chk("xover_on", 1'b1, xover_en);
    @(posedge clk);
    speed_strap <= 1'b0;
    crossover_auto_strap <= 1'b0;
    cyc(3);
    chk("xover_off", 1'b0, xover_en);
    rd(OFS_STATUS, 32'h26, "status");
    rd(OFS_BYTE_TEST, BYTE_TEST_VAL, "byte_test");
    rd(OFS_LINK_CFG, 32'h5, "link_cfg");
  endtask

  // Sleep, wake event, chip select alone, then a full write cycle.
  task automatic t_sleep(input logic [31:0] cfg, input logic [1:0] idle,
                         input logic [1:0] act, input logic [31:0] d);
    wr(OFS_CTRL, cfg | 32'h8);
    cyc(1);
    chk("asleep", 1'b1, asleep);
    chk("pin_idle", idle, {pin_oe, pin_out});
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    cyc(2);
    chk("pin_active", act, {pin_oe, pin_out});
    chk("event_keeps_sleep", 1'b1, asleep);
    i_rwsc_host.pins(1'b0, 1'b1);
    cyc(2);
    chk("select_only", 1'b1, asleep);
    i_rwsc_host.pins(1'b1, 1'b1);
    i_rwsc_host.wake(d);
    chk("awake", 1'b0, asleep);
    wr(OFS_INT_MASK, 32'h0);
    rd(OFS_INT_MASK, 32'h4, "mask_after_wake");
    rd(OFS_INT_STAT, 32'h7, "wake_flags");
    wr(OFS_INT_STAT, 32'h7);
  endtask

  // External reset: sync delay, full clear, strap recapture, write gating again.
  task automatic t_ext_reset();
    wr(OFS_INT_MASK, 32'h7);
    @(posedge clk);
    ext_reset_low <= 1'b0;
    cyc(1);
    chk("sync_delay", 1'b1, sp100);
    cyc(4);
    ext_reset_low <= 1'b1;
    cyc(30);
    chk("speed10", 1'b0, sp100);
    chk("autoneg_off", 1'b0, autoneg);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CTRL, 32'h0, "ctrl_after_reset");
    rd(OFS_INT_MASK, 32'h0, "mask_after_reset");
  endtask

  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    cyc(25); // Power-on count plus synchroniser.
    t_read_first();
    t_straps();
    t_sleep(32'h3, 2'b10, 2'b11, 32'h0);
    t_sleep(32'h5, 2'b00, 2'b10, 32'hffff_ffff);
    t_ext_reset();
    conclude();
  end
endmodule
